/* pkg/nip_params.svh */
// Register offsets, field positions and reset values of the node block
`ifndef NIP_PARAMS_SVH
`define NIP_PARAMS_SVH
`define NIP_ADDR_W 12
`define NIP_OFF_NODE 12'h0E8
`define NIP_OFF_PHY 12'h0EC
`define NIP_OFF_ISTAT 12'h100
`define NIP_OFF_IMASK 12'h104
`define NIP_VALID_BIT 31
`define NIP_ROOT_BIT 30
`define NIP_CPS_BIT 27
`define NIP_SEG_HI 15
`define NIP_SEG_LO 6
`define NIP_IDX_HI 5
`define NIP_IDX_LO 0
`define NIP_RDONE_BIT 31
`define NIP_RBIDX_HI 27
`define NIP_RBIDX_LO 24
`define NIP_RBVAL_HI 23
`define NIP_RBVAL_LO 16
`define NIP_RDREQ_BIT 15
`define NIP_WRREQ_BIT 14
`define NIP_TIDX_HI 11
`define NIP_TIDX_LO 8
`define NIP_WVAL_HI 7
`define NIP_WVAL_LO 0
`define NIP_SEG_RST 10'h3FF
`define NIP_IDX_RST 6'h3F
`define NIP_INT_W 4
`define NIP_INT_BUSRST 0
`define NIP_INT_NODEOK 1
`define NIP_INT_PHYRX 2
`define NIP_INT_SENT 3
`endif

/* pkg/nip_pkg.sv */
// Types shared by the node identity and physical-layer access block
package nip_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] index;
        logic [7:0] value;
    } nip_phy_req_t;
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [7:0] value;
    } nip_phy_rx_t;
    typedef enum logic [1:0] {
        NIP_ST_IDLE = 2'b01,
        NIP_ST_ACCESS = 2'b10
    } nip_apb_st_t;
endpackage : nip_pkg

/* rtl/nip_node_id_phy_regs.sv */
// Node identity and physical-layer register access bank on APB
//
// Function
// - Node ID is segment and index concatenated
// - Valid flag clears on reset, sets on index
// - Root flag set when root during reset
// - Cable power flag follows physical layer report
// - Reserved identity bits always read zero
// - Bus segment writable, hardware may update
// - Index loaded after self-ID, not writable
// - Register gives physical-layer read/write access
// - Read complete clears on request, sets on arrival
// - One request bit at a time, cleared when sent
// - Capture index and value of received register
// - Target and write value; value unused for reads
`timescale 1ns/1ns
`include "nip_params.svh"

module nip_node_id_phy_regs (
    input wire logic core_clk, // 50 MHz clock
    input wire logic rst_n, // Asynchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [`NIP_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire logic busResetDet, // Serial bus reset seen, pulse
    input wire logic selfIdDone, // New node index delivered, pulse
    input wire logic [5:0] selfIdNodeIndex, // Index from physical layer
    input wire logic phyIsRoot, // Physical layer reports root
    input wire logic cablePowerOk, // Cable power in good condition
    input wire logic segUpdate, // Hardware load of bus segment
    input wire logic [9:0] segUpdateValue, // Segment to load
    input wire logic phyReqSent, // Physical layer took the request
    input wire nip_pkg::nip_phy_rx_t phyRx, // Register transfer received
    output nip_pkg::nip_phy_req_t phyReq, // Pending request to PHY
    output logic [15:0] nodeId, // Node identifier
    output logic irq // Level interrupt
);

    nip_pkg::nip_apb_st_t state_ff;
    nip_pkg::nip_apb_st_t nxt_state;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic valid_ff;
    logic nxt_valid;
    logic resetActive_ff;
    logic nxt_resetActive;
    logic root_ff;
    logic nxt_root;
    logic cps_ff;
    logic [9:0] seg_ff;
    logic [9:0] nxt_seg;
    logic [5:0] idx_ff;
    logic [5:0] nxt_idx;
    nip_pkg::nip_phy_req_t req_ff;
    nip_pkg::nip_phy_req_t nxt_req;
    logic phy_read_complete_ff;
    logic nxt_phy_read_complete;
    logic [3:0] rbIdx_ff;
    logic [7:0] rbVal_ff;
    logic [`NIP_INT_W-1:0] stat_ff;
    logic [`NIP_INT_W-1:0] nxt_stat;
    logic [`NIP_INT_W-1:0] mask_ff;
    logic [`NIP_INT_W-1:0] nxt_mask;
    logic irq_ff;

    // Address decode
    wire setupPh = psel & ~penable;
    wire wrEn = psel & penable & pready_ff & pwrite;
    wire hitNode = (paddr == `NIP_OFF_NODE);
    wire hitPhy = (paddr == `NIP_OFF_PHY);
    wire hitStat = (paddr == `NIP_OFF_ISTAT);
    wire hitMask = (paddr == `NIP_OFF_IMASK);
    wire hitAny = hitNode | hitPhy | hitStat | hitMask;
    wire reqBusy = req_ff.rd | req_ff.wr;
    wire wrNode = wrEn & hitNode;
    // A new request cannot overwrite one still waiting for the PHY
    wire wrPhy = wrEn & hitPhy & ~reqBusy;
    wire wrStat = wrEn & hitStat;
    wire wrMask = wrEn & hitMask;
    wire swRd = pwdata[`NIP_RDREQ_BIT];
    wire swWr = pwdata[`NIP_WRREQ_BIT];
    wire newReq = wrPhy & (swRd | swWr);
    wire reqDone = phyReqSent & reqBusy;

    // Read views; reserved bits are tied low
    wire [31:0] nodeRd = {valid_ff, root_ff, 2'h0, cps_ff, 11'h000,
                          seg_ff, idx_ff};
    wire [31:0] phyRd = {phy_read_complete_ff, 3'h0, rbIdx_ff, rbVal_ff,
                         req_ff.rd, req_ff.wr, 2'h0,
                         req_ff.index, req_ff.value};
    wire [31:0] statRd = {{(32-`NIP_INT_W){1'b0}}, stat_ff};
    wire [31:0] maskRd = {{(32-`NIP_INT_W){1'b0}}, mask_ff};
    wire [31:0] rdMux = hitNode ? nodeRd :
                        hitPhy ? phyRd :
                        hitStat ? statRd :
                        hitMask ? maskRd : 32'h0000_0000;

    // APB answer: access phase always lasts exactly one cycle
    always_comb begin
        case (state_ff)
            nip_pkg::NIP_ST_IDLE: begin
                nxt_state = setupPh ? nip_pkg::NIP_ST_ACCESS
                                    : nip_pkg::NIP_ST_IDLE;
            end
            nip_pkg::NIP_ST_ACCESS: begin
                nxt_state = nip_pkg::NIP_ST_IDLE;
            end
            default: begin
                nxt_state = nip_pkg::NIP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= nip_pkg::NIP_ST_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            pready_ff <= (nxt_state == nip_pkg::NIP_ST_ACCESS);
            pslverr_ff <= setupPh & ~hitAny;
            prdata_ff <= (setupPh & ~pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // Node identity; a new bus reset outranks a same-cycle index
    assign nxt_valid = busResetDet ? 1'b0 :
                       selfIdDone ? 1'b1 : valid_ff;
    assign nxt_resetActive = busResetDet ? 1'b1 :
                             selfIdDone ? 1'b0 : resetActive_ff;
    // Root is only sampled while reset processing is under way
    assign nxt_root = busResetDet ? 1'b0 :
                      (resetActive_ff & phyIsRoot) ? 1'b1 :
                      root_ff;
    // Hardware load wins so a bridge update is never lost
    assign nxt_seg = segUpdate ? segUpdateValue :
                     wrNode ? pwdata[`NIP_SEG_HI:`NIP_SEG_LO] :
                     seg_ff;
    // Software writes never reach the index
    assign nxt_idx = selfIdDone ? selfIdNodeIndex : idx_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            resetActive_ff <= 1'b0;
            root_ff <= 1'b0;
            cps_ff <= 1'b0;
            seg_ff <= `NIP_SEG_RST;
            idx_ff <= `NIP_IDX_RST;
        end else begin
            valid_ff <= nxt_valid;
            resetActive_ff <= nxt_resetActive;
            root_ff <= nxt_root;
            cps_ff <= cablePowerOk;
            seg_ff <= nxt_seg;
            idx_ff <= nxt_idx;
        end
    end

    // Physical-layer access; read wins if software sets both bits
    always_comb begin
        nxt_req = req_ff;
        if (wrPhy) begin
            nxt_req.rd = swRd;
            nxt_req.wr = swWr & ~swRd;
            nxt_req.index = pwdata[`NIP_TIDX_HI:`NIP_TIDX_LO];
            nxt_req.value = pwdata[`NIP_WVAL_HI:`NIP_WVAL_LO];
        end else if (reqDone) begin
            nxt_req.rd = 1'b0;
            nxt_req.wr = 1'b0;
        end
    end

    // An arriving transfer wins over a same-cycle request
    assign nxt_phy_read_complete = phyRx.valid ? 1'b1 :
                        newReq ? 1'b0 : phy_read_complete_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ff <= '0;
            phy_read_complete_ff <= 1'b0;
            rbIdx_ff <= 4'h0;
            rbVal_ff <= 8'h00;
        end else begin
            req_ff <= nxt_req;
            phy_read_complete_ff <= nxt_phy_read_complete;
            if (phyRx.valid) begin
                rbIdx_ff <= phyRx.index;
                rbVal_ff <= phyRx.value;
            end
        end
    end

    // Sticky events, write one to clear; a new event wins
    wire [`NIP_INT_W-1:0] events = {reqDone, phyRx.valid,
                                    selfIdDone, busResetDet};
    wire [`NIP_INT_W-1:0] clrBits = wrStat ? pwdata[`NIP_INT_W-1:0]
                                           : {`NIP_INT_W{1'b0}};
    assign nxt_stat = (stat_ff & ~clrBits) | events;
    assign nxt_mask = wrMask ? pwdata[`NIP_INT_W-1:0] : mask_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= {`NIP_INT_W{1'b0}};
            mask_ff <= {`NIP_INT_W{1'b0}};
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff <= |(nxt_stat & nxt_mask);
        end
    end

    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign phyReq = req_ff;
    assign nodeId = {seg_ff, idx_ff};
    assign irq = irq_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence sReqWrite;
        newReq && !phyRx.valid;
    endsequence

    sequence sReqPending;
        reqBusy && !phy_read_complete_ff;
    endsequence

    sequence sReqSent;
        reqDone && !wrPhy;
    endsequence

    node_id_out_a: assert property (
        selfIdDone && !segUpdate && !wrNode |=>
            nodeId == {$past(seg_ff), $past(selfIdNodeIndex)})
        else $error("node id not segment and index");

    valid_clear_a: assert property (
        busResetDet |=> !valid_ff ##1 (valid_ff == $past(selfIdDone)
                                       || !valid_ff))
        else $error("valid flag not cleared by bus reset");

    index_load_a: assert property (
        selfIdDone && !busResetDet |=>
            valid_ff && idx_ff == $past(selfIdNodeIndex))
        else $error("node index not loaded after self-id");

    root_set_a: assert property (
        resetActive_ff && phyIsRoot && !busResetDet |=> root_ff)
        else $error("root flag not set");

    cable_power_a: assert property (
        ##1 cps_ff == $past(cablePowerOk))
        else $error("cable power flag does not follow input");

    node_rsvd_a: assert property (
        pready_ff && hitNode && !pwrite |->
            prdata[29:28] == 2'h0 && prdata[26:16] == 11'h000)
        else $error("reserved identity bits not zero");

    index_nowrite_a: assert property (
        wrNode && !selfIdDone |=> $stable(idx_ff))
        else $error("software changed the node index");

    segment_write_a: assert property (
        wrNode && !segUpdate |=>
            seg_ff == $past(pwdata[`NIP_SEG_HI:`NIP_SEG_LO]))
        else $error("bus segment write lost");

    req_issue_a: assert property (
        sReqWrite |=> sReqPending ##0
            req_ff.index == $past(pwdata[`NIP_TIDX_HI:`NIP_TIDX_LO]))
        else $error("request not raised or read complete not cleared");

    req_clear_a: assert property (
        sReqSent |=> !reqBusy ##1 !reqBusy || $past(wrPhy))
        else $error("request bit not cleared once sent");

    one_req_a: assert property (
        !(req_ff.rd && req_ff.wr))
        else $error("read and write requested together");

    readback_a: assert property (
        phyRx.valid |=> phy_read_complete_ff && rbIdx_ff == $past(phyRx.index)
                        && rbVal_ff == $past(phyRx.value))
        else $error("received register not captured");

    ready_pulse_a: assert property (
        pready_ff |=> !pready_ff)
        else $error("ready held longer than one cycle");

    busy_hold_a: assert property (
        wrEn && hitPhy && reqBusy |=>
            $stable(req_ff.index) && $stable(req_ff.value))
        else $error("request changed while still pending");

endmodule : nip_node_id_phy_regs

/* verification/nip_node_id_phy_regs_test.sv */
// Self-checking bench for the node identity and PHY access registers
`timescale 1ns/1ns
`include "nip_params.svh"
module nip_node_id_phy_regs_test;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic busResetDet, selfIdDone, phyIsRoot, cablePowerOk, segUpdate;
    logic [5:0] selfIdNodeIndex;
    logic [9:0] segUpdateValue;
    logic phyReqSent, err;
    nip_pkg::nip_phy_rx_t phyRx;
    nip_pkg::nip_phy_req_t phyReq;
    logic [15:0] nodeId;
    int fails = 0;
    int checks = 0;

    nip_node_id_phy_regs DUT (
        .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .busResetDet, .selfIdDone,
        .selfIdNodeIndex, .phyIsRoot, .cablePowerOk, .segUpdate,
        .segUpdateValue, .phyReqSent, .phyRx, .phyReq, .nodeId, .irq
    );
    nip_phy_model #(.DLY(12)) phy (
        .core_clk, .rst_n, .phyReq, .phyReqSent, .phyRx
    );

    task automatic chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fails++;
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask : rdc

    // Bounded polling: the PHY answers at its own pace
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, `NIP_OFF_PHY, 32'h0);
            n++;
        end while (rdv[b] !== v && n < 40);
        if (rdv[b] !== v) fails++;
    endtask : poll

    task report_and_stop;
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        repeat (4000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        busResetDet = 1'b0;
        selfIdDone = 1'b0;
        selfIdNodeIndex = 6'h00;
        phyIsRoot = 1'b0;
        cablePowerOk = 1'b0;
        segUpdate = 1'b0;
        segUpdateValue = 10'h000;
        repeat (20) @(posedge core_clk);
        chk({16'h0, nodeId}, 32'h0000_FFFF);
        rst_n <= 1'b1;
        rdc(`NIP_OFF_NODE, 32'h0000_FFFF);
        rdc(`NIP_OFF_PHY, 32'h0);
        apb(1'b1, `NIP_OFF_NODE, 32'h0000_0040);
        rdc(`NIP_OFF_NODE, 32'h0000_007F);
        apb(1'b1, `NIP_OFF_NODE, 32'hFFFF_FFFF);
        rdc(`NIP_OFF_NODE, 32'h0000_FFFF);
        apb(1'b1, `NIP_OFF_PHY, 32'h7000_3000);
        rdc(`NIP_OFF_PHY, 32'h0);
        @(posedge core_clk);
        busResetDet <= 1'b1;
        phyIsRoot <= 1'b1;
        cablePowerOk <= 1'b1;
        @(posedge core_clk);
        busResetDet <= 1'b0;
        selfIdNodeIndex <= 6'h05; // index kept off 63
        selfIdDone <= 1'b1;
        @(posedge core_clk);
        selfIdDone <= 1'b0;
        rdc(`NIP_OFF_NODE, 32'hC800_FFC5);
        chk({16'h0, nodeId}, 32'h0000_FFC5);
        @(posedge core_clk);
        segUpdate <= 1'b1;
        segUpdateValue <= 10'h001;
        @(posedge core_clk);
        segUpdate <= 1'b0;
        rdc(`NIP_OFF_NODE, 32'hC800_0045);
        @(posedge core_clk);
        busResetDet <= 1'b1;
        phyIsRoot <= 1'b0;
        cablePowerOk <= 1'b0;
        @(posedge core_clk);
        busResetDet <= 1'b0;
        rdc(`NIP_OFF_NODE, 32'h0000_0045);
        apb(1'b1, `NIP_OFF_PHY, 32'h0000_8355);
        #1;
        chk({18'h0, phyReq}, 32'h0000_2355);
        poll(31, 1'b1);
        chk(rdv, 32'h83A3_0355);
        apb(1'b1, `NIP_OFF_PHY, 32'h0000_479A);
        #1;
        chk({18'h0, phyReq}, 32'h0000_179A);
        rdc(`NIP_OFF_PHY, 32'h03A3_479A);
        apb(1'b1, `NIP_OFF_PHY, 32'h0);
        rdc(`NIP_OFF_PHY, 32'h03A3_479A);
        poll(14, 1'b0);
        chk(rdv, 32'h03A3_079A);
        apb(1'b1, `NIP_OFF_PHY, 32'h0000_8700);
        poll(31, 1'b1);
        chk(rdv, 32'h879A_0700);
        rdc(`NIP_OFF_ISTAT, 32'h0000_000F);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `NIP_OFF_IMASK, 32'h0000_0004);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `NIP_OFF_ISTAT, 32'h0000_0004);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        rdc(`NIP_OFF_ISTAT, 32'h0000_000B);
        rdc(`NIP_OFF_IMASK, 32'h0000_0004);
        apb(1'b0, 12'h0F0, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, err}, 32'h1);
        report_and_stop();
    end
endmodule : nip_node_id_phy_regs_test

/* verification/nip_phy_model.sv */
// Behavioural physical-layer register file answering link requests
`timescale 1ns/1ns
module nip_phy_model #(
    parameter int DLY = 12
) (
    input wire logic core_clk, // Link clock
    input wire logic rst_n, // Async reset
    input wire nip_pkg::nip_phy_req_t phyReq, // Request from link
    output logic phyReqSent, // Request taken, pulse
    output nip_pkg::nip_phy_rx_t phyRx // Register transfer back
);
    logic [7:0] regs [16];
    int cnt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            phyReqSent <= 1'b0;
            phyRx <= '0;
            for (int i = 0; i < 16; i++) regs[i] <= {4'hA, i[3:0]};
        end else begin
            phyReqSent <= 1'b0;
            // Fields toggle outside valid so nothing leans on stale data
            phyRx <= {1'b0, ~phyRx.index, ~phyRx.value};
            if ((phyReq.rd || phyReq.wr) && !phyReqSent) begin
                cnt <= cnt + 1;
                if (cnt == DLY) begin
                    cnt <= 0;
                    phyReqSent <= 1'b1;
                    if (phyReq.rd)
                        phyRx <= {1'b1, phyReq.index, regs[phyReq.index]};
                    else
                        regs[phyReq.index] <= phyReq.value;
                end
            end
        end
    end
endmodule : nip_phy_model
